/* File: baud_timer_interrupt_ctrl_tb.sv */
// testbench: baud generator, counter/timer and interrupt control
`timescale 1ns/1ps
`default_nettype none
module baud_timer_interrupt_ctrl_tb;
   import bti_pkg::*;
   logic clk, rst, cs_n, rd_n, wr_n, m68k, pin6, ctclk, rxl, toen;
   logic oe, rvalid, ct_out, irq_n;
   logic [3:0] addr, ext, c16;
   logic [7:0] din, dout, ev, rdata, v;
   logic [4:0] op, op_oe;
   logic [7:0] expq[$];
   int mismatches = 0;
   int checks_done = 0;
   int n0, n3;
   bti_top bti_top_inst (.CLOCK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .RD_N_I(rd_n),
      .WR_N_I(wr_n), .ADDR_I(addr), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe),
      .BUS_MODE_68K_I(m68k), .INPUT_PIN_SIX_I(pin6), .EVENT_I(ev), .CT_EXT_CLK_I(ctclk),
      .EXT_CLK_I(ext), .RX_LOAD_I(rxl), .TIMEOUT_EN_I(toen), .CLK16_EN_O(c16),
      .CT_OUT_O(ct_out), .IRQ_OUT_N_O(irq_n), .OUT_PINS_O(op), .OUT_PINS_OE_O(op_oe));
   bti_host bti_host_inst (.clk_i(clk), .data_i(dout), .data_oe_i(oe), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(din), .rdata_o(rdata),
      .rvalid_o(rvalid));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bti_host_inst.access('{1'b0, 1'b1, a, d}, 1'b0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      expq.push_back(e);
      bti_host_inst.access('{1'b1, 1'b0, a, 8'h00}, 1'b1);
   endtask
   task automatic cmd(input logic [3:0] a);
      bti_host_inst.access('{1'b1, 1'b0, a, 8'h00}, 1'b0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         ctclk = 1'b1;
         cyc(3);
         ctclk = 1'b0;
         cyc(3);
      end
   endtask
   // ----------------------------------------
   // clock, watchdog and read watcher
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   always @(posedge clk) begin
      if (c16[0] === 1'b1) n0++;
      if (c16[3] === 1'b1) n3++;
      if (rvalid === 1'b1) begin
         if (expq.size() == 0) chk("read note", 16'h0001, 16'h0000);
         else chk("read data", rdata, expq.pop_front());
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      m68k = 1'b0;
      pin6 = 1'b1;
      ctclk = 1'b0;
      rxl = 1'b0;
      toen = 1'b0;
      ext = 4'h0;
      ev = 8'h00;
      v = 8'($urandom(32'h3448));
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("irq_n", irq_n, 1'b1);
      rd(ADR_VECTOR, VECTOR_RST);
      ev = 8'($urandom()) & 8'hf7;
      wr(ADR_IRQ, 8'h00);
      rd(ADR_IRQ, ev);
      cyc(2);
      chk("irq_n", irq_n, 1'b1);
      for (int i = 0; i < 8; i++) begin
         if (i != ISR_CT_BIT) begin
            ev = 8'h01 << i;
            wr(ADR_IRQ, ev);
            cyc(2);
            chk("irq_n", irq_n, 1'b0);
            wr(ADR_IRQ, ~ev);
            cyc(2);
            chk("irq_n", irq_n, 1'b1);
         end
      end
      // counter mode from the external counter clock, divisor three
      ev = 8'h00;
      wr(ADR_AUX, 8'h00);
      wr(ADR_DIV_HI, 8'h00);
      wr(ADR_DIV_LO, 8'h03);
      wr(ADR_OPCR, 8'h01);
      wr(ADR_IRQ, 8'h08);
      cmd(ADR_START);
      rd(ADR_DIV_HI, 8'h00);
      rd(ADR_DIV_LO, 8'h03);
      chk("ct_out", ct_out, 1'b1);
      tick(2);
      chk("ct_out", ct_out, 1'b1);
      tick(1);
      chk("ct_out", ct_out, 1'b0);
      rd(ADR_IRQ, 8'h08);
      chk("irq_n", irq_n, 1'b0);
      chk("pin3 oe", op_oe[0], 1'b1);
      chk("pin3", op[0], 1'b0);
      cmd(ADR_STOP);
      rd(ADR_IRQ, 8'h00);
      cyc(2);
      chk("irq_n", irq_n, 1'b1);
      chk("pin3 oe", op_oe[0], 1'b0);
      // timer mode, divisor two: toggles every two ticks
      wr(ADR_AUX, 8'h40);
      wr(ADR_DIV_LO, 8'h02);
      cmd(ADR_START);
      for (int k = 1; k < 4; k++) begin
         tick(2);
         chk("ct_out", ct_out, !k[0]);
      end
      rd(ADR_IRQ, 8'h08);
      cmd(ADR_STOP);
      rd(ADR_IRQ, 8'h00);
      // timeout: a received character reloads, the next tick restarts
      wr(ADR_AUX, 8'h00);
      wr(ADR_DIV_LO, 8'h03);
      toen = 1'b1;
      rxl = 1'b1;
      cyc(1);
      rxl = 1'b0;
      tick(1);
      rd(ADR_DIV_LO, 8'h03);
      tick(2);
      chk("ct_out", ct_out, 1'b1);
      tick(1);
      chk("ct_out", ct_out, 1'b0);
      rd(ADR_IRQ, 8'h08);
      cmd(ADR_STOP);
      rd(ADR_IRQ, 8'h08);
      rxl = 1'b1;
      cyc(1);
      rxl = 1'b0;
      cyc(2);
      rd(ADR_IRQ, 8'h00);
      toen = 1'b0;
      // extended rate code only runs at 230.4k with mode bit 0 set, else at 50 baud
      wr(ADR_MODE0, 8'h01);
      wr(ADR_CLKSEL, 8'hc0);
      wr(ADR_RATE_A, 8'h1e);
      cyc(100);
      n0 = 0;
      n3 = 0;
      repeat (4) begin
         ext[3] = 1'b1;
         cyc(3);
         ext[3] = 1'b0;
         cyc(3);
      end
      cyc(3367);
      chk("rate 230k", 1'(n0 >= 99 && n0 <= 101), 1'b1);
      chk("ext edges", 16'(n3), 16'h0004);
      wr(ADR_MODE0, 8'h00);
      cyc(100);
      n0 = 0;
      cyc(3391);
      chk("rate 50", 1'(n0 <= 1), 1'b1);
      // vector on the data bus while acknowledge is held low
      wr(ADR_VECTOR, v);
      rd(ADR_VECTOR, v);
      m68k = 1'b1;
      pin6 = 1'b0;
      cyc(2);
      chk("vector", dout, v);
      chk("vector oe", oe, 1'b1);
      pin6 = 1'b1;
      cyc(2);
      chk("vector oe", oe, 1'b0);
      m68k = 1'b0;
      cyc(2);
      end_sim();
   end
endmodule
`default_nettype wire

/* File: bti_host.sv */
// host model: parallel bus master driving the register interface
`timescale 1ns/1ps
`default_nettype none
module bti_host
   import bti_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] data_i,
   input wire logic data_oe_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [3:0] addr_o,
   output logic [7:0] data_o,
   output logic [7:0] rdata_o,
   output logic rvalid_o
);
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 4'h0;
      data_o = 8'ha5;
      rdata_o = 8'h00;
      rvalid_o = 1'b0;
   end
   // ----------------------------------------
   // one access, strobes held until the answer edge
   // ----------------------------------------
   task automatic access(input bti_bus_t b, input bit note);
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b0;
      rd_n_o = ~b.rd;
      wr_n_o = ~b.wr;
      addr_o = b.addr;
      data_o = b.wr ? b.data : ~data_o;
      @(posedge clk_i);
      if (b.rd) begin
         @(posedge clk_i);
         #1;
         // an undriven bus must never pass for read data
         rdata_o = (data_oe_i === 1'b1) ? data_i : 8'hxx;
         rvalid_o = note;
      end else begin
         #1;
      end
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      // released bus shows no stale value
      data_o = ~data_o;
      @(posedge clk_i);
      #1;
      rvalid_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: bti_pkg.sv */
// package: constants and types for the baud, timer and interrupt block
package bti_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [3:0] ADR_MODE0 = 4'h0;
   localparam logic [3:0] ADR_CLKSEL = 4'h1;
   localparam logic [3:0] ADR_RATE_A = 4'h2;
   localparam logic [3:0] ADR_RATE_B = 4'h3;
   localparam logic [3:0] ADR_AUX = 4'h4;
   localparam logic [3:0] ADR_IRQ = 4'h5;
   localparam logic [3:0] ADR_DIV_HI = 4'h6;
   localparam logic [3:0] ADR_DIV_LO = 4'h7;
   localparam logic [3:0] ADR_VECTOR = 4'hc;
   localparam logic [3:0] ADR_OPCR = 4'hd;
   localparam logic [3:0] ADR_OPDATA = 4'he;
   localparam logic [3:0] ADR_START = 4'he;
   localparam logic [3:0] ADR_STOP = 4'hf;
   // ----------------------------------------
   // reset values and fields
   // ----------------------------------------
   localparam logic [7:0] VECTOR_RST = 8'h0f;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int MR0_EXT_BIT = 0;
   localparam int AUX_TIMER_BIT = 6;
   localparam int AUX_REF_BIT = 5;
   localparam int AUX_DIV16_BIT = 4;
   localparam int ISR_CT_BIT = 3;
   localparam int OPCR_CT_OUT_BIT = 5;
   localparam int N_SEL = 4;
   localparam int N_OP = 5;
   // isr bit driven onto each of output pins three to seven in interrupt use
   localparam logic [14:0] OP_IRQ_MAP = {3'h4, 3'h0, 3'h5, 3'h1, 3'h3};
   localparam logic [1:0] CKSEL_GEN_A = 2'h0;
   localparam logic [1:0] CKSEL_GEN_B = 2'h1;
   localparam logic [1:0] CKSEL_CT = 2'h2;
   localparam logic [3:0] PRE16_LAST = 4'hf;
   localparam logic [15:0] CT_ONE = 16'h0001;
   // ----------------------------------------
   // reference rate
   // ----------------------------------------
   localparam logic [31:0] CLOCK_HZ = 32'h0773_5940;
   localparam logic [31:0] XTAL_HZ = 32'h0038_4000;
   // 16x divisor of the reference per rate code; the top four need mode bit 0
   localparam logic [4:0] RATE_EXT_FIRST = 5'h1c;
   localparam logic [12:0] RATE_DIV [32] = '{
      13'h1200, 13'h0c00, 13'h082f, 13'h06b1, 13'h0600, 13'h0480, 13'h0300, 13'h0180,
      13'h0100, 13'h00db, 13'h00c0, 13'h0090, 13'h0080, 13'h0073, 13'h0060, 13'h0048,
      13'h0040, 13'h0030, 13'h0024, 13'h0020, 13'h0018, 13'h0012, 13'h0010, 13'h000c,
      13'h0009, 13'h0008, 13'h0006, 13'h0900, 13'h0004, 13'h0002, 13'h0001, 13'h1200};
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [7:0] data;
   } bti_bus_t;
   typedef enum logic [1:0] {CT_STOPPED, CT_RUNNING, CT_RELOAD} bti_ct_state_t;
endpackage

/* File: bti_top.sv */
// top: baud generator, clock selectors, counter/timer and interrupt control
// Notes on behaviour
// - one active-low interrupt request fed by seven external event inputs and the counter ready bit
// - status register shows every active condition regardless of the mask
// - output pins three to seven can be open-drain active-low interrupt outputs
// - generator gives 28 standard rates from 50 to 38.4K baud
// - mode register zero bit 0 adds 57.6k, 115.2k and 230.4k baud
// - every generator clock runs at sixteen times its baud rate
// - rates are exact only from a 3.6864 MHz reference
// - four selectors pick generator, counter output or external timing per direction
// - counter/timer is a 16-bit divider with counter, timer and timeout modes
// - aux control bits 6 to 4 choose counter clock source and mode
// - counter output serves as baud source and as an output pin signal
// - ready bit 3 sets on each falling edge of the counter output
// - outside timeout mode a read at one address starts the counter, at another stops it in counter mode only
// - start copies both divisor registers into the working count
// - stop clears the counter ready bit except in timeout mode
// - timer mode makes a square wave with half period divisor ticks
// - counter mode counts to zero, drops output, sets ready, wraps on
// - timeout mode: each received character reloads and restarts the counter
// - in 68000 bus style input pin six is interrupt acknowledge
// - vector is driven on the data bus while acknowledge is low
// - vector register at 0xC resets to 0x0F
`timescale 1ns/1ps
`default_nettype none
module bti_top (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CS_N_I,
   input wire logic RD_N_I,
   input wire logic WR_N_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] DATA_I,
   output logic [7:0] DATA_O,
   output logic DATA_OE_O,
   input wire logic BUS_MODE_68K_I,
   input wire logic INPUT_PIN_SIX_I,
   input wire logic [7:0] EVENT_I,
   input wire logic CT_EXT_CLK_I,
   input wire logic [3:0] EXT_CLK_I,
   input wire logic RX_LOAD_I,
   input wire logic TIMEOUT_EN_I,
   output logic [3:0] CLK16_EN_O,
   output logic CT_OUT_O,
   output logic IRQ_OUT_N_O,
   output logic [4:0] OUT_PINS_O,
   output logic [4:0] OUT_PINS_OE_O
);
   import bti_pkg::*;

   function automatic logic bti_hit(input bti_bus_t b, input logic [3:0] a,
                                    input logic wr);
      bti_hit = (wr ? b.wr : b.rd) && (b.addr == a);
   endfunction
   // divisor of the reference for each rate code, 16x clocks
   function automatic logic [12:0] bti_rate_div(input logic [4:0] code,
                                                input logic ext);
      // without mode bit 0 the extended codes fall back to the slowest rate
      bti_rate_div = (code >= RATE_EXT_FIRST && !ext) ? RATE_DIV[0] : RATE_DIV[code];
   endfunction
   // ----------------------------------------
   // host bus strobes
   // ----------------------------------------
   logic rd_act, wr_act, rd_act_reg, wr_act_reg;
   bti_bus_t req;
   // in 68000 style the write strobe pin carries read/not-write
   assign rd_act = !CS_N_I && (BUS_MODE_68K_I ? WR_N_I : !RD_N_I);
   assign wr_act = !CS_N_I && !WR_N_I;
   always_ff @(posedge CLOCK_I) begin
      rd_act_reg <= !RST_I && rd_act;
      wr_act_reg <= !RST_I && wr_act;
   end
   always_comb begin
      req.rd = rd_act && !rd_act_reg;
      req.wr = wr_act && !wr_act_reg;
      req.addr = ADDR_I;
      req.data = DATA_I;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] mode_reg_zero, clksel_reg, aux_control_reg, irq_mask_reg;
   logic [7:0] divisor_high_reg, divisor_low_reg, opcr_reg, opdata_reg;
   logic [7:0] interrupt_vector_reg;
   logic [4:0] rate_reg [2];
   logic [7:0] irq_status_reg;
   logic ct_ready_reg;
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         mode_reg_zero <= BYTE_RST;
         clksel_reg <= BYTE_RST;
         aux_control_reg <= BYTE_RST;
         irq_mask_reg <= BYTE_RST;
         divisor_high_reg <= BYTE_RST;
         divisor_low_reg <= BYTE_RST;
         opcr_reg <= BYTE_RST;
         opdata_reg <= BYTE_RST;
         rate_reg[0] <= BYTE_RST[4:0];
         rate_reg[1] <= BYTE_RST[4:0];
         interrupt_vector_reg <= VECTOR_RST;
      end else begin
         if (bti_hit(req, ADR_MODE0, 1'b1)) mode_reg_zero <= req.data;
         if (bti_hit(req, ADR_CLKSEL, 1'b1)) clksel_reg <= req.data;
         if (bti_hit(req, ADR_RATE_A, 1'b1)) rate_reg[0] <= req.data[4:0];
         if (bti_hit(req, ADR_RATE_B, 1'b1)) rate_reg[1] <= req.data[4:0];
         if (bti_hit(req, ADR_AUX, 1'b1)) aux_control_reg <= req.data;
         if (bti_hit(req, ADR_IRQ, 1'b1)) irq_mask_reg <= req.data;
         if (bti_hit(req, ADR_DIV_HI, 1'b1)) divisor_high_reg <= req.data;
         if (bti_hit(req, ADR_DIV_LO, 1'b1)) divisor_low_reg <= req.data;
         if (bti_hit(req, ADR_OPCR, 1'b1)) opcr_reg <= req.data;
         if (bti_hit(req, ADR_OPDATA, 1'b1)) opdata_reg <= req.data;
         if (bti_hit(req, ADR_VECTOR, 1'b1)) interrupt_vector_reg <= req.data;
      end
   end
   // status is live: sources outside report levels, bit 3 is local
   always_comb begin
      irq_status_reg = EVENT_I;
      irq_status_reg[ISR_CT_BIT] = ct_ready_reg;
   end

   // ----------------------------------------
   // read data and vector
   // ----------------------------------------
   logic [7:0] rd_mux;
   logic [15:0] count_reg;
   always_comb begin
      unique case (ADDR_I)
         ADR_MODE0: rd_mux = mode_reg_zero;
         ADR_AUX: rd_mux = aux_control_reg;
         ADR_IRQ: rd_mux = irq_status_reg;
         ADR_DIV_HI: rd_mux = count_reg[15:8];
         ADR_DIV_LO: rd_mux = count_reg[7:0];
         ADR_VECTOR: rd_mux = interrupt_vector_reg;
         default: rd_mux = BYTE_RST;
      endcase
   end
   logic iack_n;
   assign iack_n = INPUT_PIN_SIX_I;
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         DATA_O <= BYTE_RST;
         DATA_OE_O <= 1'b0;
      end else if (BUS_MODE_68K_I && !iack_n) begin
         DATA_O <= interrupt_vector_reg;
         DATA_OE_O <= 1'b1;
      end else begin
         DATA_O <= rd_mux;
         DATA_OE_O <= rd_act;
      end
   end

   // ----------------------------------------
   // reference tick and baud generator
   // ----------------------------------------
   // fractional accumulator: average tick rate equals the nominal crystal
   logic [31:0] acc_reg, acc_next;
   logic ref_tick;
   assign acc_next = acc_reg + XTAL_HZ;
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         acc_reg <= '0;
         ref_tick <= 1'b0;
      end else if (acc_next >= CLOCK_HZ) begin
         acc_reg <= acc_next - CLOCK_HZ;
         ref_tick <= 1'b1;
      end else begin
         acc_reg <= acc_next;
         ref_tick <= 1'b0;
      end
   end
   logic [1:0] gen_pulse;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_gen
         logic [12:0] cnt_reg, rate_div;
         assign rate_div = bti_rate_div(rate_reg[g], mode_reg_zero[MR0_EXT_BIT]);
         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               cnt_reg <= '0;
               gen_pulse[g] <= 1'b0;
            end else if (ref_tick && (cnt_reg == '0 || cnt_reg >= rate_div)) begin
               // a count left above a newly chosen divisor restarts at once
               cnt_reg <= rate_div - 13'h1;
               gen_pulse[g] <= 1'b1;
            end else begin
               if (ref_tick) cnt_reg <= cnt_reg - 13'h1;
               gen_pulse[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // clock selectors
   // ----------------------------------------
   logic ct_out_reg, ct_out_d_reg;
   logic [3:0] ext_d_reg;
   logic ct_rise, ct_fall;
   assign ct_rise = ct_out_reg && !ct_out_d_reg;
   assign ct_fall = ct_out_d_reg && !ct_out_reg;
   generate
      for (genvar i = 0; i < N_SEL; i++) begin : g_sel
         logic [1:0] src;
         assign src = clksel_reg[2*i +: 2];
         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               ext_d_reg[i] <= 1'b0;
               CLK16_EN_O[i] <= 1'b0;
            end else begin
               ext_d_reg[i] <= EXT_CLK_I[i];
               unique case (src)
                  CKSEL_GEN_A: CLK16_EN_O[i] <= gen_pulse[0];
                  CKSEL_GEN_B: CLK16_EN_O[i] <= gen_pulse[1];
                  CKSEL_CT: CLK16_EN_O[i] <= ct_rise;
                  default: CLK16_EN_O[i] <= EXT_CLK_I[i] && !ext_d_reg[i];
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // counter/timer
   // ----------------------------------------
   logic ct_ext_d_reg, base_tick, ct_tick, timer_mode, timeout;
   logic [3:0] pre16_reg;
   logic cmd_start, cmd_stop;
   logic [15:0] divisor;
   bti_ct_state_t ct_state;
   assign divisor = {divisor_high_reg, divisor_low_reg};
   assign timeout = TIMEOUT_EN_I;
   // timeout forces counting mode and takes start/stop away from the host
   assign timer_mode = aux_control_reg[AUX_TIMER_BIT] && !timeout;
   assign cmd_start = bti_hit(req, ADR_START, 1'b0) && !timeout;
   assign cmd_stop = bti_hit(req, ADR_STOP, 1'b0) && !timeout;
   assign base_tick = aux_control_reg[AUX_REF_BIT] ? ref_tick
                      : (CT_EXT_CLK_I && !ct_ext_d_reg);
   assign ct_tick = aux_control_reg[AUX_DIV16_BIT]
                    ? (base_tick && pre16_reg == PRE16_LAST) : base_tick;
   always_ff @(posedge CLOCK_I) begin
      ct_ext_d_reg <= !RST_I && CT_EXT_CLK_I;
      if (RST_I) pre16_reg <= '0;
      else if (base_tick) pre16_reg <= pre16_reg + 4'h1;
   end
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ct_state <= CT_STOPPED;
         count_reg <= '0;
         ct_out_reg <= 1'b1;
      end else if (timeout && RX_LOAD_I) begin
         ct_state <= CT_RELOAD;
      end else if (cmd_start) begin
         count_reg <= divisor;
         ct_out_reg <= 1'b1;
         ct_state <= CT_RUNNING;
      end else if (cmd_stop && !timer_mode) begin
         // a running square wave ignores stop
         ct_state <= CT_STOPPED;
      end else begin
         unique case (ct_state)
            CT_STOPPED: ;
            CT_RUNNING: begin
               if (ct_tick && timer_mode) begin
                  if (count_reg <= CT_ONE) begin
                     count_reg <= divisor;
                     ct_out_reg <= !ct_out_reg;
                  end else begin
                     count_reg <= count_reg - CT_ONE;
                  end
               end else if (ct_tick) begin
                  count_reg <= count_reg - CT_ONE;
                  if (count_reg == CT_ONE) ct_out_reg <= 1'b0;
               end
            end
            CT_RELOAD: begin
               if (ct_tick) begin
                  count_reg <= divisor;
                  ct_out_reg <= 1'b1;
                  ct_state <= CT_RUNNING;
               end
            end
         endcase
      end
   end
   assign CT_OUT_O = ct_out_reg;
   // set beats any clear in the same cycle
   always_ff @(posedge CLOCK_I) begin
      ct_out_d_reg <= RST_I || ct_out_reg;
      ct_ready_reg <= !RST_I && (ct_fall
                      || (ct_ready_reg && !cmd_stop && !(timeout && RX_LOAD_I)));
   end

   // ----------------------------------------
   // interrupt outputs
   // ----------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         IRQ_OUT_N_O <= 1'b1;
         OUT_PINS_O <= '0;
         OUT_PINS_OE_O <= '0;
      end else begin
         IRQ_OUT_N_O <= !(|(irq_status_reg & irq_mask_reg));
         for (int j = 0; j < N_OP; j++) begin
            if (opcr_reg[j]) begin
               OUT_PINS_O[j] <= 1'b0;
               OUT_PINS_OE_O[j] <= irq_status_reg[OP_IRQ_MAP[3*j +: 3]];
            end else if (j == 0 && opcr_reg[OPCR_CT_OUT_BIT]) begin
               OUT_PINS_O[j] <= ct_out_reg;
               OUT_PINS_OE_O[j] <= 1'b1;
            end else begin
               OUT_PINS_O[j] <= opdata_reg[j];
               OUT_PINS_OE_O[j] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   property p_irq_level;
      |(irq_status_reg & irq_mask_reg) && $stable(irq_status_reg & irq_mask_reg)
         |=> !IRQ_OUT_N_O;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not low");
   property p_ready_on_fall;
      $fell(ct_out_reg) |=> ct_ready_reg;
   endproperty
   a_ready_on_fall: assert property (p_ready_on_fall) else $error("ready missed");
   property p_stop_clears;
      cmd_stop && !ct_fall |=> !ct_ready_reg;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stop kept ready");
   property p_start_loads;
      cmd_start && !(timeout && RX_LOAD_I) |=> count_reg == $past(divisor) && ct_out_reg;
   endproperty
   a_start_loads: assert property (p_start_loads) else $error("start no load");
   property p_vector_reset;
      @(posedge CLOCK_I) disable iff (1'b0) RST_I |=> interrupt_vector_reg == VECTOR_RST;
   endproperty
   a_vector_reset: assert property (p_vector_reset) else $error("vector reset");
   property p_vector_drive;
      BUS_MODE_68K_I && !iack_n |=> DATA_OE_O && DATA_O == $past(interrupt_vector_reg);
   endproperty
   a_vector_drive: assert property (p_vector_drive) else $error("vector not driven");
   property p_timer_toggle;
      ct_state == CT_RUNNING && timer_mode && ct_tick && count_reg <= CT_ONE
         && !cmd_start && !(timeout && RX_LOAD_I) |=> ct_out_reg != $past(ct_out_reg);
   endproperty
   a_timer_toggle: assert property (p_timer_toggle) else $error("no toggle");
   property p_counter_zero;
      ct_state == CT_RUNNING && !timer_mode && ct_tick && count_reg == CT_ONE
         && !cmd_start && !cmd_stop && !RX_LOAD_I |=> !ct_out_reg ##1 ct_ready_reg;
   endproperty
   a_counter_zero: assert property (p_counter_zero) else $error("zero missed");
   property p_timeout_restart;
      timeout && RX_LOAD_I && !ct_fall |=> ct_state == CT_RELOAD && !ct_ready_reg;
   endproperty
   a_timeout_restart: assert property (p_timeout_restart) else $error("no reload");
   c_timer_wave: cover property (timer_mode && ct_fall);
   c_counter_done: cover property (!timer_mode && $rose(ct_ready_reg));
   c_stop_clear: cover property (ct_ready_reg ##1 cmd_stop ##1 !ct_ready_reg);
   c_vector: cover property (BUS_MODE_68K_I && !iack_n);
endmodule
`default_nettype wire
